// file: swrcr_pkg.sv
package swrcr_pkg;
   // ==========================================================
   // Command codes and framing
   // ==========================================================
   localparam logic [7:0] CMD_MODE_WR = 8'hE6;
   localparam logic [7:0] CMD_MODE_RD = 8'hE7;
   localparam logic [7:0] CMD_TRIM_WR = 8'hE8;
   localparam logic [7:0] CMD_TRIM_RD = 8'hE9;
   localparam int RW_BIT = 0;
   localparam logic [1:0] MODE_BYTES = 2'h1;
   localparam logic [1:0] TRIM_BYTES = 2'h2;
   // ==========================================================
   // Field layout and reset values
   // ==========================================================
   localparam int Y_LEVEL_LSB = 0;
   localparam int Z_LEVEL_LSB = 2;
   localparam int OVG_BIT = 4;
   localparam int TRIM_LSB = 3;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [15:0] TRIM_RESET = 16'h0010;
   localparam logic [2:0] TRIM_FIELD_RESET = 3'h0;
   // ==========================================================
   // Power levels
   // ==========================================================
   localparam logic [1:0] LEVEL_OFF = 2'h0;
   localparam logic [1:0] LOW_POWER_LEVEL = 2'h1;
   localparam logic [1:0] MEDIUM_POWER_LEVEL = 2'h2;
   localparam logic [1:0] HIGH_POWER_LEVEL = 2'h3;
   // ==========================================================
   // Parser states
   // ==========================================================
   typedef enum logic [2:0] {
      SWRCR_IDLE = 3'b001,
      SWRCR_DATA = 3'b010,
      SWRCR_SKIP = 3'b100
   } swrcr_state_e;
endpackage : swrcr_pkg

// file: swrcr_cmd_if.sv
`timescale 1ns/1ps
interface swrcr_cmd_if;
   logic wr_strobe;
   logic rd_load;
   logic sel_trim;
   logic [1:0] idx;
   logic [7:0] data;
   modport parser (output wr_strobe, rd_load, sel_trim, idx, data);
   modport regs (input wr_strobe, rd_load, sel_trim, idx, data);
endinterface : swrcr_cmd_if

// file: swrcr_parser.sv
`timescale 1ns/1ps
module swrcr_parser (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_frame,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   swrcr_cmd_if.parser bus
);
   import swrcr_pkg::*;
   swrcr_state_e state_r, state_nxt;
   logic read_r, sel_trim_r;
   logic [1:0] idx_r, idx_nxt;

   wire is_mode = (i_byte[7:1] == CMD_MODE_WR[7:1]);
   wire is_trim = (i_byte[7:1] == CMD_TRIM_WR[7:1]);
   wire cmd_ok = is_mode | is_trim;
   wire in_idle = (state_r == SWRCR_IDLE);
   wire in_data = (state_r == SWRCR_DATA);
   wire [1:0] len = sel_trim_r ? TRIM_BYTES : MODE_BYTES;
   wire [1:0] idx_inc = idx_r + 2'h1;
   wire last = (idx_inc == len);

   // Bytes count only inside a frame; command bit 0 picks read or write
   wire strobe = i_frame & i_byte_valid;
   wire take_cmd = in_idle & strobe & cmd_ok;
   wire take_data = in_data & strobe;

   assign bus.wr_strobe = take_data & ~read_r;
   assign bus.rd_load = (take_cmd & i_byte[RW_BIT])
                      | (take_data & read_r & ~last);
   assign bus.sel_trim = take_cmd ? is_trim : sel_trim_r;
   assign bus.idx = take_cmd ? 2'h0 : (read_r ? idx_inc : idx_r);
   assign bus.data = i_byte;

   always_comb begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      case (state_r)
         SWRCR_IDLE: begin
            idx_nxt = 2'h0;
            if (i_byte_valid) begin
               state_nxt = cmd_ok ? SWRCR_DATA : SWRCR_SKIP;
            end
         end
         SWRCR_DATA: begin
            if (i_byte_valid) begin
               idx_nxt = idx_inc;
               if (last) begin
                  state_nxt = SWRCR_SKIP;
               end
            end
         end
         SWRCR_SKIP: state_nxt = SWRCR_SKIP;
         default: state_nxt = SWRCR_IDLE;
      endcase
      if (!i_frame) begin
         state_nxt = SWRCR_IDLE;
         idx_nxt = 2'h0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= SWRCR_IDLE;
         idx_r <= 2'h0;
         read_r <= 1'b0;
         sel_trim_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         if (take_cmd) begin
            read_r <= i_byte[RW_BIT];
            sel_trim_r <= is_trim;
         end
      end
   end
endmodule : swrcr_parser

// file: swrcr_top.sv
`timescale 1ns/1ps
//
// Contract
// - Mode register written by E6h, read by E7h; one data byte follows.
// - Data bit 4 enables switcher over-voltage guard.
// - Mode 00 off, 01 low, 10 medium, 11 high power and clock.
// - Auto select 0: writes accepted, replaced by state mode on state change.
// - Auto select 1: field sets mode directly, state changes ignored.
// - Writing 00 to both fields shuts supply down regardless of auto select.
// - Mode command ignores the per-channel enable selection.
// - Mode register resets to 00h, leaving both regulators off.
// - Trim field is sign-magnitude in 1.25 V steps, plus or minus 3.75 V.
// - Auto select 0: device picks power mode from current system state.
module swrcr_top (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_frame,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   output logic [7:0] o_rd_byte,
   input wire logic [1:0] i_channel_enable,
   input wire logic i_regulator_y_auto_select,
   input wire logic i_regulator_z_auto_select,
   input wire logic i_state_change,
   input wire logic [1:0] i_state_y_level,
   input wire logic [1:0] i_state_z_level,
   output logic [1:0] o_regulator_y_power_level,
   output logic [1:0] o_regulator_z_power_level,
   output logic o_overvoltage_guard_enable,
   output logic o_switcher_shutdown,
   output logic [2:0] o_y_trim_code,
   output logic [2:0] o_z_trim_code,
   output logic signed [2:0] o_y_trim_steps,
   output logic signed [2:0] o_z_trim_steps
);
   import swrcr_pkg::*;
   // ==========================================================
   // Helpers
   // ==========================================================
   // Sign-magnitude code to signed count of 1.25 V steps
   function automatic logic signed [2:0] trim_steps(input logic [2:0] c);
      logic [2:0] mag;
      mag = {1'b0, c[1:0]};
      trim_steps = c[2] ? 3'(-mag) : mag;
   endfunction : trim_steps

   // Next level: host write beats a same-cycle state change
   function automatic logic [1:0] level_next(input logic wr,
      input logic [1:0] wr_lvl, input logic follow,
      input logic [1:0] state_lvl, input logic [1:0] cur);
      level_next = wr ? wr_lvl : (follow ? state_lvl : cur);
   endfunction : level_next

   // ==========================================================
   // Command parser
   // ==========================================================
   swrcr_cmd_if cmd ();

   swrcr_parser u_parser (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_frame(i_frame),
      .i_byte_valid(i_byte_valid),
      .i_byte(i_byte),
      .bus(cmd.parser)
   );

   // ==========================================================
   // Mode control register
   // ==========================================================
   logic [1:0] y_level_r, y_level_nxt;
   logic [1:0] z_level_r, z_level_nxt;
   logic ovg_r;
   logic [2:0] y_trim_r, z_trim_r;
   logic [7:0] rd_byte_r, rd_byte_nxt;

   // Channel enable takes no part in this write
   wire wr_mode = cmd.wr_strobe & ~cmd.sel_trim;
   wire [1:0] wr_y = cmd.data[Y_LEVEL_LSB +: 2];
   wire [1:0] wr_z = cmd.data[Z_LEVEL_LSB +: 2];
   wire y_follow = i_state_change & ~i_regulator_y_auto_select;
   wire z_follow = i_state_change & ~i_regulator_z_auto_select;

   assign y_level_nxt = level_next(wr_mode, wr_y, y_follow,
                                   i_state_y_level, y_level_r);
   assign z_level_nxt = level_next(wr_mode, wr_z, z_follow,
                                   i_state_z_level, z_level_r);

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         y_level_r <= MODE_RESET[Y_LEVEL_LSB +: 2];
         z_level_r <= MODE_RESET[Z_LEVEL_LSB +: 2];
         ovg_r <= MODE_RESET[OVG_BIT];
      end else begin
         y_level_r <= y_level_nxt;
         z_level_r <= z_level_nxt;
         if (wr_mode) begin
            ovg_r <= cmd.data[OVG_BIT];
         end
      end
   end

   // ==========================================================
   // Voltage trim, channel 1 drives Y and channel 2 drives Z
   // ==========================================================
   wire wr_trim_hi = cmd.wr_strobe & cmd.sel_trim & (cmd.idx == 2'h0);
   wire [2:0] wr_trim = cmd.data[TRIM_LSB +: 3];

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         y_trim_r <= TRIM_FIELD_RESET;
         z_trim_r <= TRIM_FIELD_RESET;
      end else begin
         if (wr_trim_hi & i_channel_enable[0]) begin
            y_trim_r <= wr_trim;
         end
         if (wr_trim_hi & i_channel_enable[1]) begin
            z_trim_r <= wr_trim;
         end
      end
   end

   // ==========================================================
   // Read-back
   // ==========================================================
   // Reserved bits read as zero except the second trim byte, which reads 10h; trim reads Y unless only channel 2 is enabled
   wire [2:0] rd_trim = (i_channel_enable[0] | ~i_channel_enable[1]) ?
                        y_trim_r : z_trim_r;
   wire [7:0] rd_mode = {3'h0, ovg_r, z_level_r, y_level_r};
   wire [7:0] rd_trim_hi = {2'h0, rd_trim, 3'h0};
   wire [7:0] rd_trim_lo = TRIM_RESET[7:0];
   wire [7:0] rd_sel = ~cmd.sel_trim ? rd_mode :
                       (cmd.idx == 2'h0) ? rd_trim_hi : rd_trim_lo;

   assign rd_byte_nxt = cmd.rd_load ? rd_sel : rd_byte_r;

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_byte_r <= 8'h00;
      end else begin
         rd_byte_r <= rd_byte_nxt;
      end
   end

   // ==========================================================
   // Regulator outputs
   // ==========================================================
   assign o_rd_byte = rd_byte_r;
   assign o_regulator_y_power_level = y_level_r;
   assign o_regulator_z_power_level = z_level_r;
   assign o_overvoltage_guard_enable = ovg_r;
   assign o_switcher_shutdown = (y_level_r == LEVEL_OFF) &
                                (z_level_r == LEVEL_OFF);
   assign o_y_trim_code = y_trim_r;
   assign o_z_trim_code = z_trim_r;
   assign o_y_trim_steps = trim_steps(y_trim_r);
   assign o_z_trim_steps = trim_steps(z_trim_r);
endmodule : swrcr_top

// file: swrcr_chk.sv
`timescale 1ns/1ps
// ============================================================
// Port-level checks on the regulator control block
module swrcr_chk (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_frame,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   input wire logic [7:0] o_rd_byte,
   input wire logic i_regulator_y_auto_select,
   input wire logic i_state_change,
   input wire logic [1:0] i_state_y_level,
   input wire logic [1:0] o_regulator_y_power_level,
   input wire logic [1:0] o_regulator_z_power_level,
   input wire logic o_overvoltage_guard_enable,
   input wire logic o_switcher_shutdown,
   input wire logic [2:0] o_y_trim_code,
   input wire logic signed [2:0] o_y_trim_steps
);
   import swrcr_pkg::*;
   logic [1:0] cnt_r;
   logic [7:0] cmd_r;
   wire logic [1:0] y = o_regulator_y_power_level;
   wire logic [4:0] mode = {o_overvoltage_guard_enable,
                            o_regulator_z_power_level, y};
   wire logic [2:0] mag = {1'b0, o_y_trim_code[1:0]};
   wire logic first = i_frame && i_byte_valid && cnt_r == 2'h0;
   wire logic wr_now = i_frame && i_byte_valid && cnt_r == 2'h1 &&
                       cmd_r == CMD_MODE_WR;
   wire logic [1:0] cnt_nxt = !i_frame ? 2'h0 :
      (i_byte_valid && cnt_r != 2'h3) ? cnt_r + 2'h1 : cnt_r;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (first) cmd_r <= i_byte;
   end
   sequence mode_wr_s; wr_now; endsequence
   sequence mode_rd_s; first && i_byte == CMD_MODE_RD; endsequence
   sequence state_s; i_state_change && !wr_now; endsequence
   reset_off_a: assert property ($rose(i_arst_n) |-> mode == 5'h00)
      else $error("levels not off after reset");
   shut_both_a: assert property (
      o_switcher_shutdown == (mode[3:0] == 4'h0))
      else $error("shutdown flag disagrees with levels");
   mode_write_a: assert property (
      mode_wr_s |=> mode == $past(i_byte[4:0]))
      else $error("mode write not applied");
   mode_read_a: assert property (
      mode_rd_s |=> o_rd_byte == {3'h0, $past(mode)})
      else $error("mode read data wrong");
   auto_hold_a: assert property (
      state_s ##0 i_regulator_y_auto_select |=> $stable(y))
      else $error("state change moved a direct level");
   auto_follow_a: assert property (
      state_s ##0 !i_regulator_y_auto_select
      |=> y == $past(i_state_y_level))
      else $error("level did not follow state");
   rd_hold_a: assert property (!i_byte_valid |=> $stable(o_rd_byte))
      else $error("read data changed without strobe");
   trim_sign_a: assert property (
      o_y_trim_steps ==
      (o_y_trim_code[2] ? -$signed(mag) : $signed(mag)))
      else $error("trim steps wrong");
endmodule : swrcr_chk

// file: swrcr_host.sv
`timescale 1ns/1ps
// ============================================================
// Host sending command frames
module swrcr_host (
   input wire logic i_mclk,
   output logic o_frame,
   output logic o_byte_valid,
   output logic [7:0] o_byte
);
   import swrcr_pkg::*;
   initial {o_frame, o_byte_valid, o_byte} = 10'h000;
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] d,
                       input int n);
      logic [7:0] b;
      @(negedge i_mclk);
      o_frame = 1'b1;
      o_byte_valid = 1'b1;
      o_byte = cmd;
      for (int i = 0; i < n; i++) begin
         b = (cmd == CMD_TRIM_WR) ? d & 8'h38 : d & 8'h1F;
         if (i == 1) b = 8'h10;
         @(negedge i_mclk);
         o_byte = b;
      end
      @(negedge i_mclk);
      o_frame = 1'b0;
      o_byte_valid = 1'b0;
      o_byte = ~o_byte;
   endtask : xfer
endmodule : swrcr_host

// file: tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Top-level bench
module tb_top;
   import swrcr_pkg::*;
   logic clk = 1'b0;
   logic rst_n, frame, bv, ay, az, sc, ovg, sd;
   logic [7:0] bt, rd, d, em, w;
   logic [1:0] ch, sy, sz, y, z;
   logic [2:0] ty, tz, t, ety, etz;
   logic signed [2:0] sty, stz;
   int err_count = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   swrcr_host swrcr_host_inst (.i_mclk(clk), .o_frame(frame),
      .o_byte_valid(bv), .o_byte(bt));
   swrcr_top swrcr_top_inst (.i_mclk(clk), .i_arst_n(rst_n), .i_frame(frame),
      .i_byte_valid(bv), .i_byte(bt), .o_rd_byte(rd), .i_channel_enable(ch),
      .i_regulator_y_auto_select(ay), .i_regulator_z_auto_select(az),
      .i_state_change(sc), .i_state_y_level(sy), .i_state_z_level(sz),
      .o_regulator_y_power_level(y), .o_regulator_z_power_level(z),
      .o_overvoltage_guard_enable(ovg), .o_switcher_shutdown(sd),
      .o_y_trim_code(ty), .o_z_trim_code(tz), .o_y_trim_steps(sty),
      .o_z_trim_steps(stz));
   function automatic logic [5:0] trim_exp(input logic [2:0] c);
      logic [2:0] m;
      m = {1'b0, c[1:0]};
      return {c, c[2] ? 3'h0 - m : m};
   endfunction : trim_exp
   task automatic chk(input string nm, input logic [7:0] s,
                      input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check_reset;
      chk("reset", {ovg, sd, z, y, rd[1:0]}, 8'h40);
      chk("reset_rd", rd, 8'h00);
      chk("reset_trim", {2'h0, ty, tz}, 8'h00);
      chk("reset_steps", {2'h0, sty, stz}, 8'h00);
   endtask : check_reset
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(38378));
      {rst_n, ay, az, sc, sy, sz, ch} = 10'h003;
      {ety, etz, w} = 14'h0000;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      check_reset;
      for (int k = 0; k < 24; k++) begin
         if (k == 12) begin
            rst_n = 1'b0;
            {ety, etz, w} = 14'h0000;
            repeat (2) @(negedge clk);
            check_reset;
            rst_n = 1'b1;
            check_reset;
         end
         d = 8'($urandom);
         if (k < 2) d = k[0] ? 8'h1F : 8'h00;
         if (d[1:0] == 2'h3 && w[1:0] != 2'h3) d[1:0] = 2'h2;
         if (d[3:2] == 2'h3 && w[3:2] != 2'h3) d[3:2] = 2'h2;
         {ay, az, ch, t} = 7'($urandom);
         swrcr_host_inst.xfer(CMD_MODE_WR, d, 1);
         em = d & 8'h1F;
         chk("mode", {3'h0, ovg, z, y}, em);
         chk("off", {7'h0, sd}, {7'h0, em[3:0] == 4'h0});
         swrcr_host_inst.xfer(CMD_MODE_RD, d, 0);
         chk("mode_rd", rd, em);
         {sy, sz} = 4'($urandom);
         sc = 1'b1;
         @(negedge clk);
         sc = 1'b0;
         w = {4'h0, az ? em[3:2] : sz, ay ? em[1:0] : sy};
         chk("state", {4'h0, z, y}, w);
         swrcr_host_inst.xfer(CMD_TRIM_WR, {2'h0, t, 3'h0}, 2);
         if (ch[0]) ety = t;
         if (ch[1]) etz = t;
         chk("trim_y", {2'h0, ty, sty}, {2'h0, trim_exp(ety)});
         chk("trim_z", {2'h0, tz, stz}, {2'h0, trim_exp(etz)});
         swrcr_host_inst.xfer(CMD_TRIM_RD, d, 0);
         chk("trim_hi", rd, {2'h0, ((ch == 2'h2) ? etz : ety), 3'h0});
         swrcr_host_inst.xfer(CMD_TRIM_RD, d, 1);
         chk("trim_lo", rd, 8'h10);
      end
      tally_and_finish;
   end
endmodule : tb_top
bind swrcr_top swrcr_chk swrcr_chk_inst (.i_mclk(i_mclk),
   .i_arst_n(i_arst_n), .i_frame(i_frame), .i_byte_valid(i_byte_valid),
   .i_byte(i_byte), .o_rd_byte(o_rd_byte),
   .i_regulator_y_auto_select(i_regulator_y_auto_select),
   .i_state_change(i_state_change), .i_state_y_level(i_state_y_level),
   .o_regulator_y_power_level(o_regulator_y_power_level),
   .o_regulator_z_power_level(o_regulator_z_power_level),
   .o_overvoltage_guard_enable(o_overvoltage_guard_enable),
   .o_switcher_shutdown(o_switcher_shutdown),
   .o_y_trim_code(o_y_trim_code), .o_y_trim_steps(o_y_trim_steps));
